// *** pcg_ctrl.sv ***
// port clock gating control: gating registers, mode select, port fault
`timescale 1ns/1ns

//------------------------------------------
// top module
//------------------------------------------
// Notes on behaviour
// - each enable bit clocks one port unit
// - access to unclocked port gives bus fault
// - all enable bits zero after reset
// - run, sleep, deep registers per mode
// - low-power registers only when auto gating set
// - bits 0..4 enable ports A..E
// - bits 31:5 read zero, software preserves
// - registers at 0x108, 0x118, 0x128
module pcg_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone register slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pcg_pkg::pcg_aw-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // power mode from the power controller, same clock
   input wire pcg_pkg::pcg_mode_t mode_i,
   // port access request from the system bus, same clock
   input wire logic port_req_i,
   input wire logic [2:0] port_sel_i,
   output logic port_fwd_o,
   output logic port_fault_o,
   // gated clock enables, one per port
   output logic [pcg_pkg::pcg_num_ports-1:0] port_clk_en_o,
   output logic irq_o
);
   import pcg_pkg::*;

   //------------------------------------------
   // register state
   //------------------------------------------
   logic [pcg_num_ports-1:0] run_port_clock_enable_r, run_port_clock_enable_nxt;
   logic [pcg_num_ports-1:0] sleep_port_clock_enable_r, sleep_port_clock_enable_nxt;
   logic [pcg_num_ports-1:0] deep_sleep_port_clock_enable_r, deep_sleep_port_clock_enable_nxt;
   logic auto_sleep_gating_select_r, auto_sleep_gating_select_nxt;
   logic [pcg_irq_w-1:0] irq_stat_r, irq_stat_nxt;
   logic [pcg_irq_w-1:0] irq_mask_r, irq_mask_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic ack_r, ack_nxt;
   logic [pcg_num_ports-1:0] clk_en_r, clk_en_nxt;
   pcg_mode_t mode_r;
   pcg_pst_t pst_r, pst_nxt;
   logic fault_ev, mode_ev;
   logic wr_en, rd_en;
   logic [pcg_num_ports-1:0] sel_gate;
   logic [31:0] wmask;

   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   //------------------------------------------
   // register file and bus answer
   //------------------------------------------
   always_comb begin
      logic [31:0] wv;
      wv = wb_dat_i & wmask;
      run_port_clock_enable_nxt = run_port_clock_enable_r;
      sleep_port_clock_enable_nxt = sleep_port_clock_enable_r;
      deep_sleep_port_clock_enable_nxt = deep_sleep_port_clock_enable_r;
      auto_sleep_gating_select_nxt = auto_sleep_gating_select_r;
      irq_mask_nxt = irq_mask_r;
      irq_stat_nxt = irq_stat_r;
      dat_nxt = dat_r;
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      if (wr_en) begin
         case (wb_adr_i)
            // bits above 4 are dropped, so they stay zero
            pcg_run_off: begin
               if (wb_sel_i[0]) begin
                  run_port_clock_enable_nxt = wv[pcg_num_ports-1:0];
               end
            end
            pcg_sleep_off: begin
               if (wb_sel_i[0]) begin
                  sleep_port_clock_enable_nxt = wv[pcg_num_ports-1:0];
               end
            end
            pcg_deep_off: begin
               if (wb_sel_i[0]) begin
                  deep_sleep_port_clock_enable_nxt = wv[pcg_num_ports-1:0];
               end
            end
            pcg_cfg_off: begin
               if (wb_sel_i[3]) begin
                  auto_sleep_gating_select_nxt = wb_dat_i[pcg_auto_gate_bit];
               end
            end
            pcg_irq_stat_off: begin
               irq_stat_nxt = irq_stat_r & ~wv[pcg_irq_w-1:0];
            end
            pcg_irq_mask_off: begin
               if (wb_sel_i[0]) begin
                  irq_mask_nxt = wv[pcg_irq_w-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      if (fault_ev) begin
         irq_stat_nxt[pcg_irq_fault_bit] = 1'b1;
      end
      if (mode_ev) begin
         irq_stat_nxt[pcg_irq_mode_bit] = 1'b1;
      end
      if (rd_en) begin
         case (wb_adr_i)
            pcg_run_off: dat_nxt = {27'h0, run_port_clock_enable_r};
            pcg_sleep_off: dat_nxt = {27'h0, sleep_port_clock_enable_r};
            pcg_deep_off: dat_nxt = {27'h0, deep_sleep_port_clock_enable_r};
            pcg_cfg_off: begin
               dat_nxt = pcg_zero;
               dat_nxt[pcg_auto_gate_bit] = auto_sleep_gating_select_r;
            end
            pcg_irq_stat_off: dat_nxt = {30'h0, irq_stat_r};
            pcg_irq_mask_off: dat_nxt = {30'h0, irq_mask_r};
            default: dat_nxt = pcg_zero;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_port_clock_enable_r <= pcg_gate_rst;
         sleep_port_clock_enable_r <= pcg_gate_rst;
         deep_sleep_port_clock_enable_r <= pcg_gate_rst;
         auto_sleep_gating_select_r <= 1'b0;
         irq_stat_r <= pcg_irq_rst;
         irq_mask_r <= pcg_irq_rst;
         dat_r <= pcg_zero;
         ack_r <= 1'b0;
      end else begin
         run_port_clock_enable_r <= run_port_clock_enable_nxt;
         sleep_port_clock_enable_r <= sleep_port_clock_enable_nxt;
         deep_sleep_port_clock_enable_r <= deep_sleep_port_clock_enable_nxt;
         auto_sleep_gating_select_r <= auto_sleep_gating_select_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign wb_err_o = 1'b0;
   assign irq_o = |(irq_stat_r & irq_mask_r);

   //------------------------------------------
   // mode select and gated enables
   //------------------------------------------
   always_comb begin
      sel_gate = run_port_clock_enable_r;
      if (auto_sleep_gating_select_r) begin
         case (mode_i)
            pcg_mode_sleep: sel_gate = sleep_port_clock_enable_r;
            pcg_mode_deep: sel_gate = deep_sleep_port_clock_enable_r;
            default: sel_gate = run_port_clock_enable_r;
         endcase
      end
      clk_en_nxt = sel_gate;
   end

   // registered enables switch only at an edge, so a gate downstream stays glitch free
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_en_r <= pcg_gate_rst;
         mode_r <= pcg_mode_run;
      end else begin
         clk_en_r <= clk_en_nxt;
         mode_r <= mode_i;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < pcg_num_ports; gi++) begin : g_port
         assign port_clk_en_o[gi] = clk_en_r[gi];
      end
   endgenerate

   assign mode_ev = (mode_r != mode_i);

   //------------------------------------------
   // port access check
   //------------------------------------------
   always_comb begin
      pst_nxt = pcg_pst_idle;
      case (pst_r)
         pcg_pst_idle: begin
            if (port_req_i) begin
               if (port_sel_i < 3'(pcg_num_ports) && clk_en_r[port_sel_i]) begin
                  pst_nxt = pcg_pst_fwd;
               end else begin
                  pst_nxt = pcg_pst_fault;
               end
            end
         end
         default: pst_nxt = pcg_pst_idle;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pst_r <= pcg_pst_idle;
      end else begin
         pst_r <= pst_nxt;
      end
   end

   assign port_fwd_o = (pst_r == pcg_pst_fwd);
   assign port_fault_o = (pst_r == pcg_pst_fault);
   assign fault_ev = port_fault_o;

   //------------------------------------------
   // assertions
   //------------------------------------------
   a_reset_gates_off: assert property (@(posedge clk_i)
      rst_i |=> (port_clk_en_o == pcg_gate_rst))
      else $error("enables not zero after reset");
   a_run_no_auto: assert property (@(posedge clk_i) disable iff (rst_i)
      !auto_sleep_gating_select_r |=> (port_clk_en_o == $past(run_port_clock_enable_r)))
      else $error("run register not applied without auto gating");
   a_sleep_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (auto_sleep_gating_select_r && mode_i == pcg_mode_sleep)
      |=> (port_clk_en_o == $past(sleep_port_clock_enable_r)))
      else $error("sleep register not applied");
   a_deep_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (auto_sleep_gating_select_r && mode_i == pcg_mode_deep)
      |=> (port_clk_en_o == $past(deep_sleep_port_clock_enable_r)))
      else $error("deep register not applied");
   a_fault_off_port: assert property (@(posedge clk_i) disable iff (rst_i)
      (pst_r == pcg_pst_idle && port_req_i && port_sel_i == 3'h0 && !port_clk_en_o[0])
      |=> port_fault_o && !port_fwd_o)
      else $error("no fault for unclocked port");
   a_fwd_on_port: assert property (@(posedge clk_i) disable iff (rst_i)
      (pst_r == pcg_pst_idle && port_req_i && port_sel_i == 3'h4 && port_clk_en_o[4])
      |=> port_fwd_o && !port_fault_o)
      else $error("clocked port access not forwarded");
   a_write_run_reg: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == pcg_run_off && wb_sel_i == 4'hf)
      |=> (run_port_clock_enable_r == $past(wb_dat_i[4:0])))
      else $error("run register write lost");
   a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(rd_en) && ack_r && ($past(wb_adr_i) == pcg_sleep_off))
      |-> (wb_dat_o[31:5] == 27'h0) && (wb_dat_o[4:0] == $past(sleep_port_clock_enable_r)))
      else $error("sleep register read wrong");
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held over two cycles");
   a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("bus request not acknowledged");

   //------------------------------------------
   // register and flag assertions
   //------------------------------------------
   a_gates_held_reset: assert property (@(posedge clk_i)
      rst_i |=> (run_port_clock_enable_r == pcg_gate_rst)
      && (sleep_port_clock_enable_r == pcg_gate_rst)
      && (deep_sleep_port_clock_enable_r == pcg_gate_rst))
      else $error("gating registers not zero after reset");
   a_sleep_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == pcg_sleep_off && wb_sel_i[0])
      |=> (sleep_port_clock_enable_r == $past(wb_dat_i[pcg_num_ports-1:0])))
      else $error("sleep register write lost");
   a_deep_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == pcg_deep_off && wb_sel_i[0])
      |=> (deep_sleep_port_clock_enable_r == $past(wb_dat_i[pcg_num_ports-1:0])))
      else $error("deep register write lost");
   a_lane_off_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == pcg_run_off && !wb_sel_i[0])
      |=> $stable(run_port_clock_enable_r))
      else $error("run register written with lane 0 off");
   a_read_deep_reg: assert property (@(posedge clk_i) disable iff (rst_i)
      ($past(rd_en) && ack_r && ($past(wb_adr_i) == pcg_deep_off))
      |-> (wb_dat_o == {27'h0, $past(deep_sleep_port_clock_enable_r)}))
      else $error("deep register read wrong");
   a_run_in_run: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == pcg_mode_run) |=> (port_clk_en_o == $past(run_port_clock_enable_r)))
      else $error("run register not applied in run mode");
   a_fault_bad_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (pst_r == pcg_pst_idle && port_req_i && port_sel_i >= 3'(pcg_num_ports))
      |=> port_fault_o && !port_fwd_o)
      else $error("no fault for missing port");
   a_fault_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      port_fault_o |=> irq_stat_r[pcg_irq_fault_bit])
      else $error("port fault not flagged");
   a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == pcg_irq_stat_off && wb_sel_i[0]
      && wb_dat_i[pcg_irq_fault_bit] && !fault_ev)
      |=> !irq_stat_r[pcg_irq_fault_bit])
      else $error("fault flag not cleared");
   a_mode_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_ev |=> irq_stat_r[pcg_irq_mode_bit])
      else $error("mode change not flagged");
endmodule

// *** pcg_pkg.sv ***
// package of constants and types for the port clock gating control block
package pcg_pkg;
   localparam int unsigned pcg_num_ports = 5;
   localparam int unsigned pcg_aw = 12;
   // register byte offsets
   localparam logic [11:0] pcg_run_off = 12'h108;
   localparam logic [11:0] pcg_sleep_off = 12'h118;
   localparam logic [11:0] pcg_deep_off = 12'h128;
   localparam logic [11:0] pcg_cfg_off = 12'h060;
   localparam logic [11:0] pcg_irq_stat_off = 12'h200;
   localparam logic [11:0] pcg_irq_mask_off = 12'h204;
   // field positions
   localparam int unsigned pcg_auto_gate_bit = 27;
   localparam int unsigned pcg_irq_fault_bit = 0;
   localparam int unsigned pcg_irq_mode_bit = 1;
   localparam int unsigned pcg_irq_w = 2;
   // reset values
   localparam logic [4:0] pcg_gate_rst = 5'h00;
   localparam logic [1:0] pcg_irq_rst = 2'h0;
   localparam logic [31:0] pcg_zero = 32'h0000_0000;
   // power modes
   typedef enum logic [1:0] {
      pcg_mode_run,
      pcg_mode_sleep,
      pcg_mode_deep
   } pcg_mode_t;
   // dispatcher states for port accesses
   typedef enum logic [1:0] {
      pcg_pst_idle,
      pcg_pst_fwd,
      pcg_pst_fault
   } pcg_pst_t;
endpackage

// *** testbench.sv ***
// self-checking testbench of the port clock gating control block
`timescale 1ns/1ns
module testbench;
   import pcg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, wb_err_o, port_fwd_o, port_fault_o, irq_o;
   pcg_mode_t mode_i = pcg_mode_run;
   logic port_req_i = 1'b0;
   logic [2:0] port_sel_i = 3'h0;
   logic [4:0] port_clk_en_o;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h2b3b76b5;
   logic [4:0] regs [3];
   logic [11:0] offs [3] = '{pcg_run_off, pcg_sleep_off, pcg_deep_off};
   logic auto_on = 1'b0;
   logic [31:0] rd;
   logic [31:0] v;

   pcg_ctrl i_pcg_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .mode_i(mode_i),
      .port_req_i(port_req_i), .port_sel_i(port_sel_i), .port_fwd_o(port_fwd_o),
      .port_fault_o(port_fault_o), .port_clk_en_o(port_clk_en_o), .irq_o(irq_o));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   //------------------------------------------
   // helpers
   //------------------------------------------
   function automatic logic [31:0] nxt_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // classic single wishbone cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   function automatic logic [4:0] exp_en(input logic a, input pcg_mode_t m);
      if (!a || m == pcg_mode_run) begin
         return regs[0];
      end
      return (m == pcg_mode_sleep) ? regs[1] : regs[2];
   endfunction

   task automatic port(input logic [2:0] s);
      logic ok;
      logic [4:0] en;
      en = exp_en(auto_on, mode_i);
      ok = (s < 3'd5) && en[s];
      @(posedge clk_i);
      port_req_i <= 1'b1;
      port_sel_i <= s;
      @(posedge clk_i);
      port_req_i <= 1'b0;
      @(posedge clk_i);
      check(port_fwd_o, ok);
      check(port_fault_o, !ok);
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         end_of_test();
      end
   end

   //------------------------------------------
   // main sequence
   //------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wb(1'b0, offs[i], 32'h0, rd);
         check(rd, 32'h0);
      end
      check(port_clk_en_o, 32'h0);
      wb(1'b1, 12'h10c, 32'hffffffff, rd);
      wb(1'b0, 12'h10c, 32'h0, rd);
      check(rd, 32'h0);
      check(wb_err_o, 32'h0);
      wb(1'b1, pcg_irq_mask_off, 32'h1, rd);
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 3; i++) begin
            v = nxt_rand();
            if (r == 0) begin
               v = 32'hffffffff;
            end
            regs[i] = v[4:0];
            wb(1'b1, offs[i], v, rd);
            wb(1'b0, offs[i], 32'h0, rd);
            check(rd, {27'h0, regs[i]});
         end
         for (int a = 0; a < 2; a++) begin
            auto_on = a[0];
            wb(1'b1, pcg_cfg_off, {4'h0, a[0], 27'h0}, rd);
            for (int m = 0; m < 3; m++) begin
               @(posedge clk_i);
               mode_i <= pcg_mode_t'(m);
               repeat (3) @(posedge clk_i);
               check(port_clk_en_o, exp_en(auto_on, mode_i));
               for (int s = 0; s < 8; s++) begin
                  port(s[2:0]);
               end
            end
         end
      end
      wb_sel_i <= 4'he;
      wb(1'b1, pcg_run_off, 32'h0, rd);
      wb_sel_i <= 4'hf;
      wb(1'b0, pcg_run_off, 32'h0, rd);
      check(rd, {27'h0, regs[0]});
      wb(1'b0, pcg_irq_stat_off, 32'h0, rd);
      check(rd[0], 32'h1);
      check(rd[1], 32'h1);
      check(irq_o, 32'h1);
      wb(1'b1, pcg_irq_stat_off, 32'h1, rd);
      @(posedge clk_i);
      check(irq_o, 32'h0);
      wb(1'b1, pcg_irq_mask_off, 32'h0, rd);
      port(3'd7);
      @(posedge clk_i);
      check(irq_o, 32'h0);
      wb(1'b0, pcg_irq_stat_off, 32'h0, rd);
      check(rd[0], 32'h1);
      end_of_test();
   end
endmodule
